// File: src/rcr_top.sv
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Functional notes
// - command and config writes are dropped unless bits 31:24 hold 0xA5.
// - command bit 0 set with key resets the processor.
// - command bit 2 set with key resets the peripherals.
// - command bit 3 set with key drives the reset pin low.
// - status bit 0 sets on pin falling edge, clears on status read.
// - status bit 1 sets on brownout rising edge while brownout reset is off, clears on status read.
// - status bits 10:8 hold cause of last processor reset.
// - status read leaves the cause field unchanged.
// - status bit 16 shows the pin level sampled on master clock.
// - status bit 17 is high from a software command until the fourth slow tick after it, however long the pin pulse lasts.
// - config bit 0 lets a low pin level cause a pin reset.
// - config bit 4 routes pin-fall flag to interrupt when pin reset off.
// - config bit 16 routes brownout flag to the interrupt.
// - config bits 11:8 give pin pulse of 2^(n+1) slow cycles.
// - command writes are ignored while a software command is busy.
// - priority: power-up, brownout, watchdog, software, pin.
// - pin resynchronised; release takes two resync plus three startup ticks.
// - status read clears pin-fall flag and its interrupt.
module rcr_top
  import rcr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        slow_clock_i,
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe_o,
  input  wire logic        power_up_i,
  input  wire logic        brownout_i,
  input  wire logic        brownout_reset_en_i,
  input  wire logic        watchdog_fault_i,
  output logic             cpu_reset_o,
  output logic             periph_reset_o,
  output logic             irq_o
);

  // ****************************************************************
  // input synchronisers and slow clock tick
  // ****************************************************************
  logic pin_sync;
  logic brown_sync;
  logic slow_tick;

  rcr_sync #(.RESET_VAL(1'b1)) u_pin_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (pin_i),
    .sync_o    (pin_sync)
  );

  rcr_sync #(.RESET_VAL(1'b0)) u_brown_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (brownout_i),
    .sync_o    (brown_sync)
  );

  rcr_slow_tick u_tick (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .slow_clock_i (slow_clock_i),
    .tick_o       (slow_tick)
  );

  // ****************************************************************
  // ahb-lite address phase capture
  // ****************************************************************
  logic       wr_pend_reg;
  logic       rd_pend_reg;
  logic [7:0] addr_reg;

  wire addr_ok   = hsel_i & hready_i & htrans_i[1];
  wire wr_cmd    = wr_pend_reg & (addr_reg == RCR_OFS_COMMAND);
  wire wr_cfg    = wr_pend_reg & (addr_reg == RCR_OFS_CONFIG);
  wire rd_status = rd_pend_reg & (addr_reg == RCR_OFS_STATUS);
  wire key_ok    = hwdata_i[RCR_KEY_HI:RCR_KEY_LO] == RCR_KEY;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok & hwrite_i;
      rd_pend_reg <= addr_ok & ~hwrite_i;
      if (addr_ok) begin
        addr_reg <= haddr_i[7:0];
      end
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // ****************************************************************
  // config register
  // ****************************************************************
  logic [31:0] config_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      config_reg <= RCR_CONFIG_RESET;
    end else if (wr_cfg && key_ok) begin
      config_reg <= hwdata_i & RCR_CONFIG_MASK;
    end
  end

  wire       pin_reset_enable    = config_reg[RCR_CF_PINEN];
  wire       pin_fall_irq_enable = config_reg[RCR_CF_FALLIEN];
  wire       brownout_irq_enable = config_reg[RCR_CF_BROWNIEN];
  wire [3:0] ext_pulse_length    = config_reg[RCR_CF_LEN_LO +: 4];

  // ****************************************************************
  // reset state manager (slow-tick timed)
  // ****************************************************************
  rcr_state_t  state_reg;
  logic [2:0]  cause_reg;
  logic [2:0]  pend_cause_reg;
  logic        cpu_rst_reg;
  logic        per_rst_reg;
  logic        busy_reg;
  logic [3:0]  cnt_reg;
  logic [16:0] pulse_cnt_reg;
  logic        pulse_own_reg;
  logic        pin_quiet_reg;

  wire cmd_ok   = wr_cmd & key_ok & ~busy_reg;
  wire cmd_cpu  = cmd_ok & hwdata_i[RCR_CMD_CPU];
  wire cmd_per  = cmd_ok & hwdata_i[RCR_CMD_PERIPH];
  wire cmd_pin  = cmd_ok & hwdata_i[RCR_CMD_PIN];
  wire cmd_any  = cmd_cpu | cmd_per | cmd_pin;
  wire brown_rst = brown_sync & brownout_reset_en_i;
  // pin reset only when enabled and not self-driven
  wire pin_rst  = pin_reset_enable & ~pin_sync & ~pin_quiet_reg;
  wire [16:0] pulse_len = 17'(17'h0_0002 << ext_pulse_length);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_reg      <= RCR_ST_IDLE;
      cause_reg      <= RCR_CAUSE_POWER;
      pend_cause_reg <= RCR_CAUSE_POWER;
      cpu_rst_reg    <= 1'b0;
      per_rst_reg    <= 1'b0;
      busy_reg       <= 1'b0;
      cnt_reg        <= 4'h0;
    end else if (power_up_i) begin
      state_reg      <= RCR_ST_HOLD;
      pend_cause_reg <= RCR_CAUSE_POWER;
      cpu_rst_reg    <= 1'b1;
      per_rst_reg    <= 1'b1;
      busy_reg       <= 1'b0;
      cnt_reg        <= RCR_SOFT_LEN;
    end else if (brown_rst) begin
      state_reg      <= RCR_ST_HOLD;
      pend_cause_reg <= RCR_CAUSE_BROWN;
      cpu_rst_reg    <= 1'b1;
      per_rst_reg    <= 1'b1;
      busy_reg       <= 1'b0;
      cnt_reg        <= RCR_SOFT_LEN;
    end else if (watchdog_fault_i) begin
      state_reg      <= RCR_ST_HOLD;
      pend_cause_reg <= RCR_CAUSE_WDOG;
      cpu_rst_reg    <= 1'b1;
      per_rst_reg    <= 1'b1;
      busy_reg       <= 1'b0;
      cnt_reg        <= RCR_SOFT_LEN;
    end else if (cmd_any) begin
      state_reg      <= RCR_ST_HOLD;
      pend_cause_reg <= cmd_cpu ? RCR_CAUSE_SOFT : cause_reg;
      cpu_rst_reg    <= cmd_cpu;
      per_rst_reg    <= cmd_per;
      busy_reg       <= 1'b1;
      cnt_reg        <= RCR_SOFT_LEN;
    end else if (pin_rst && state_reg != RCR_ST_HOLD) begin
      state_reg      <= RCR_ST_START;
      pend_cause_reg <= RCR_CAUSE_PIN;
      cpu_rst_reg    <= 1'b1;
      per_rst_reg    <= 1'b1;
      cnt_reg        <= RCR_PIN_RELEASE_LEN;
    end else if (slow_tick) begin
      case (state_reg)
        RCR_ST_IDLE: begin
          state_reg <= RCR_ST_IDLE;
        end
        RCR_ST_HOLD, RCR_ST_START: begin
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            if (cpu_rst_reg) begin
              cause_reg <= pend_cause_reg;
            end
            state_reg   <= RCR_ST_IDLE;
            cpu_rst_reg <= 1'b0;
            per_rst_reg <= 1'b0;
            busy_reg    <= 1'b0;
          end
        end
        default: begin
          state_reg <= RCR_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // external pin pulse
  // ****************************************************************
  // pin drive
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pulse_own_reg <= 1'b0;
      pulse_cnt_reg <= 17'h0_0000;
    end else if (cmd_pin) begin
      pulse_own_reg <= 1'b1;
      pulse_cnt_reg <= pulse_len;
    end else if (pulse_own_reg && slow_tick) begin
      if (pulse_cnt_reg == 17'h0_0001) begin
        pulse_own_reg <= 1'b0;
      end
      pulse_cnt_reg <= pulse_cnt_reg - 17'h0_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pin_quiet_reg <= 1'b0;
    end else begin
      pin_quiet_reg <= cmd_pin | (pin_quiet_reg & (pulse_own_reg | ~pin_sync));
    end
  end

  assign pin_o          = 1'b0;
  assign pin_oe_o       = pulse_own_reg;
  assign cpu_reset_o    = cpu_rst_reg;
  assign periph_reset_o = per_rst_reg;

  // ****************************************************************
  // flags, status read and interrupt
  // ****************************************************************
  logic pin_level_reg;
  logic pin_last_reg;
  logic brown_last_reg;
  logic fall_flag_reg;
  logic brown_flag_reg;
  logic irq_reg;

  wire pin_fall   = pin_last_reg & ~pin_sync;
  wire brown_edge = brown_sync & ~brown_last_reg & ~brownout_reset_en_i;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pin_level_reg  <= 1'b1;
      pin_last_reg   <= 1'b1;
      brown_last_reg <= 1'b0;
      fall_flag_reg  <= 1'b0;
      brown_flag_reg <= 1'b0;
      irq_reg        <= 1'b0;
    end else begin
      pin_level_reg  <= pin_sync;
      pin_last_reg   <= pin_sync;
      brown_last_reg <= brown_sync;
      fall_flag_reg  <= pin_fall | (fall_flag_reg & ~rd_status);
      brown_flag_reg <= brown_edge | (brown_flag_reg & ~rd_status);
      irq_reg <= (fall_flag_reg & ~rd_status & pin_fall_irq_enable
                  & ~pin_reset_enable)
               | (brown_flag_reg & ~rd_status & brownout_irq_enable)
               | (pin_fall & pin_fall_irq_enable & ~pin_reset_enable)
               | (brown_edge & brownout_irq_enable);
    end
  end

  assign irq_o = irq_reg;

  // cause field not touched by reads
  wire [31:0] status_word = {14'h0000, busy_reg, pin_level_reg, 5'h00,
                             cause_reg, 6'h00, brown_flag_reg,
                             fall_flag_reg};
  wire [31:0] rd_mux = (addr_reg == RCR_OFS_STATUS) ? status_word :
                       (addr_reg == RCR_OFS_CONFIG) ? config_reg  :
                       32'h0000_0000;

  assign hrdata_o = rd_pend_reg ? rd_mux : 32'h0000_0000;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_key_cfg;
    @(posedge clk_i) disable iff (!reset_n_i)
      (wr_cfg && !key_ok) |=> $stable(config_reg);
  endproperty
  a_key_cfg: assert property (p_key_cfg) else $error("bad key changed config");

  property p_cpu_cmd;
    @(posedge clk_i) disable iff (!reset_n_i)
      (cmd_cpu && !power_up_i && !brown_rst && !watchdog_fault_i)
        |=> cpu_reset_o && busy_reg;
  endproperty
  a_cpu_cmd: assert property (p_cpu_cmd) else $error("cpu command lost");

  property p_per_cmd;
    @(posedge clk_i) disable iff (!reset_n_i)
      (cmd_per && !power_up_i && !brown_rst && !watchdog_fault_i)
        |=> periph_reset_o;
  endproperty
  a_per_cmd: assert property (p_per_cmd) else $error("periph command lost");

  property p_pin_cmd;
    @(posedge clk_i) disable iff (!reset_n_i)
      cmd_pin |=> pin_oe_o && !pin_o;
  endproperty
  a_pin_cmd: assert property (p_pin_cmd) else $error("pin not driven");

  property p_fall_set;
    @(posedge clk_i) disable iff (!reset_n_i)
      pin_fall |=> fall_flag_reg;
  endproperty
  a_fall_set: assert property (p_fall_set) else $error("fall flag missed");

  property p_read_clear;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_status && !pin_fall) |=> !fall_flag_reg ##0 $stable(cause_reg);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read clear bad");

  property p_busy_block;
    @(posedge clk_i) disable iff (!reset_n_i)
      (wr_cmd && key_ok && busy_reg && !pulse_own_reg) |=> !pin_oe_o;
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("cmd while busy");

  property p_irq_brown;
    @(posedge clk_i) disable iff (!reset_n_i)
      (brown_flag_reg && brownout_irq_enable && !rd_status) |=> irq_o;
  endproperty
  a_irq_brown: assert property (p_irq_brown) else $error("brownout irq");

endmodule

// File: src/rcr_pkg.sv
package rcr_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] RCR_OFS_COMMAND = 8'h00;
  localparam logic [7:0] RCR_OFS_STATUS  = 8'h04;
  localparam logic [7:0] RCR_OFS_CONFIG  = 8'h08;

  localparam logic [7:0]  RCR_KEY        = 8'hA5;
  localparam int          RCR_KEY_HI     = 31;
  localparam int          RCR_KEY_LO     = 24;

  // command fields
  localparam int RCR_CMD_CPU    = 0;
  localparam int RCR_CMD_PERIPH = 2;
  localparam int RCR_CMD_PIN    = 3;

  // status fields
  localparam int RCR_ST_PINFALL = 0;
  localparam int RCR_ST_BROWN   = 1;
  localparam int RCR_ST_CAUSE_LO = 8;
  localparam int RCR_ST_LEVEL   = 16;
  localparam int RCR_ST_BUSY    = 17;

  // config fields
  localparam int RCR_CF_PINEN    = 0;
  localparam int RCR_CF_FALLIEN  = 4;
  localparam int RCR_CF_LEN_LO   = 8;
  localparam int RCR_CF_BROWNIEN = 16;

  localparam logic [31:0] RCR_CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] RCR_CONFIG_MASK  = 32'h0001_0F11;

  // reset causes
  localparam logic [2:0] RCR_CAUSE_POWER  = 3'h0;
  localparam logic [2:0] RCR_CAUSE_WDOG   = 3'h2;
  localparam logic [2:0] RCR_CAUSE_SOFT   = 3'h3;
  localparam logic [2:0] RCR_CAUSE_PIN    = 3'h4;
  localparam logic [2:0] RCR_CAUSE_BROWN  = 3'h5;

  // slow-domain timing
  localparam logic [3:0] RCR_SOFT_LEN    = 4'h3;
  localparam logic [3:0] RCR_STARTUP_LEN = 4'h3;
  // pin release: two resync plus three startup ticks, counted down to zero
  localparam logic [3:0] RCR_PIN_RELEASE_LEN = 4'h4;

  // ahb
  localparam logic [1:0] RCR_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] RCR_HTRANS_SEQ    = 2'h3;

  typedef enum logic [1:0] {
    RCR_ST_IDLE,
    RCR_ST_HOLD,
    RCR_ST_START
  } rcr_state_t;

endpackage

// File: src/rcr_sync.sv
`timescale 1ns/100ps
// ****************************************************************
// three-flop synchroniser, output changes once flops 2 and 3 agree
// ****************************************************************
module rcr_sync
  import rcr_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic [2:0] pipe_reg;
  logic       sync_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pipe_reg <= {3{RESET_VAL}};
      sync_reg <= RESET_VAL;
    end else begin
      pipe_reg <= {pipe_reg[1:0], async_i};
      if (pipe_reg[1] == pipe_reg[2]) begin
        sync_reg <= pipe_reg[2];
      end
    end
  end

  assign sync_o = sync_reg;
endmodule

// File: src/rcr_slow_tick.sv
`timescale 1ns/100ps
// ****************************************************************
// slow clock edge detector: one master-clock pulse per slow rise
// ****************************************************************
module rcr_slow_tick
  import rcr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic slow_clock_i,
  output logic      tick_o
);
  logic slow_sync;
  logic slow_last_reg;
  logic tick_reg;

  rcr_sync #(.RESET_VAL(1'b0)) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (slow_clock_i),
    .sync_o    (slow_sync)
  );

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      slow_last_reg <= 1'b0;
      tick_reg      <= 1'b0;
    end else begin
      slow_last_reg <= slow_sync;
      tick_reg      <= slow_sync & ~slow_last_reg;
    end
  end

  assign tick_o = tick_reg;
endmodule

// File: verif/tb.sv
`timescale 1ns/100ps
module tb
  import rcr_pkg::*;
;
  logic        clk_i;
  logic        reset_n_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic        hwrite_i;
  logic [31:0] hwdata_i;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        slow_clock_i;
  logic        ext_pin;
  logic        pin_i;
  logic        pin_o;
  logic        pin_oe_o;
  logic        power_up_i;
  logic        brownout_i;
  logic        brownout_reset_en_i;
  logic        watchdog_fault_i;
  logic        cpu_reset_o;
  logic        periph_reset_o;
  logic        irq_o;
  logic [3:0]  slow_cnt;
  int          bad_count;
  int          tests_run;
  int          cycles;
  int          n;
  int          oe_seen;

  // open-drain pin with pull-up: low while the device pulls it
  assign pin_i = pin_oe_o ? 1'b0 : ext_pin;

  rcr_top u_dut (
    .clk_i               (clk_i),
    .reset_n_i           (reset_n_i),
    .hsel_i              (1'b1),
    .haddr_i             (haddr_i),
    .htrans_i            (htrans_i),
    .hwrite_i            (hwrite_i),
    .hsize_i             (3'h2),
    .hwdata_i            (hwdata_i),
    .hready_i            (hreadyout_o),
    .hrdata_o            (hrdata_o),
    .hreadyout_o         (hreadyout_o),
    .hresp_o             (hresp_o),
    .slow_clock_i        (slow_clock_i),
    .pin_i               (pin_i),
    .pin_o               (pin_o),
    .pin_oe_o            (pin_oe_o),
    .power_up_i          (power_up_i),
    .brownout_i          (brownout_i),
    .brownout_reset_en_i (brownout_reset_en_i),
    .watchdog_fault_i    (watchdog_fault_i),
    .cpu_reset_o         (cpu_reset_o),
    .periph_reset_o      (periph_reset_o),
    .irq_o               (irq_o)
  );

  // ****************************************************************
  // clocks and watchdog timer of the run
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // slow clock is one sixteenth of the master clock
  always @(posedge clk_i) begin
    slow_cnt     <= slow_cnt + 4'h1;
    slow_clock_i <= slow_cnt[3];
    cycles       <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge clk_i);
    haddr_i  <= {24'h00_0000, a};
    hwrite_i <= w;
    htrans_i <= RCR_HTRANS_NONSEQ;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rdv = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, a, d, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0000_0000, v);
    check(v & m, e);
  endtask

  function automatic logic [31:0] cause_w(input logic [2:0] c);
    return {21'h00_0000, c, 8'h00};
  endfunction

  // waits until no reset output and no pin drive remains
  task automatic wait_quiet(output int cnt);
    cnt = 0;
    while ((cpu_reset_o | periph_reset_o | pin_oe_o) !== 1'b0 &&
           cnt < 2000) begin
      @(posedge clk_i);
      if (pin_oe_o === 1'b1)
        oe_seen++;
      cnt++;
    end
    if (cnt >= 2000)
      bad_count++;
  endtask

  task automatic pin_blip();
    ext_pin <= 1'b0;
    repeat (60) @(posedge clk_i);
    ext_pin <= 1'b1;
    repeat (60) @(posedge clk_i);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset_n_i = 1'b0;
    haddr_i = 32'h0000_0000;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hwdata_i = 32'h0000_0000;
    slow_cnt = 4'h0;
    slow_clock_i = 1'b0;
    ext_pin = 1'b1;
    power_up_i = 1'b0;
    brownout_i = 1'b0;
    brownout_reset_en_i = 1'b0;
    watchdog_fault_i = 1'b0;
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    oe_seen = 0;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    rd_chk(RCR_OFS_STATUS, 32'hFFFF_FFFF, 32'h0001_0000);
    rd_chk(RCR_OFS_CONFIG, 32'hFFFF_FFFF, RCR_CONFIG_RESET);
    rd_chk(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    check({hreadyout_o, hresp_o}, 2'b10);
    wr(RCR_OFS_CONFIG, 32'h5A00_0F11);
    rd_chk(RCR_OFS_CONFIG, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(RCR_OFS_CONFIG, 32'hA5FF_FFFF);
    rd_chk(RCR_OFS_CONFIG, 32'hFFFF_FFFF, RCR_CONFIG_MASK);
    wr(RCR_OFS_CONFIG, 32'hA500_0000);
    wr(RCR_OFS_COMMAND, 32'h5A00_0001);
    repeat (4) @(posedge clk_i);
    check(cpu_reset_o, 1'b0);
    // processor command, then a refused command while busy
    wr(RCR_OFS_COMMAND, 32'hA500_0001);
    repeat (2) @(posedge clk_i);
    check({cpu_reset_o, periph_reset_o}, 2'b10);
    rd_chk(RCR_OFS_STATUS, 32'h0002_0000, 32'h0002_0000);
    wr(RCR_OFS_COMMAND, 32'hA500_0008);
    oe_seen = 0;
    wait_quiet(n);
    check(oe_seen, 0);
    rd_chk(RCR_OFS_STATUS, 32'h0002_0700, cause_w(RCR_CAUSE_SOFT));
    rd_chk(RCR_OFS_STATUS, 32'h0000_0700, cause_w(RCR_CAUSE_SOFT));
    // peripheral command leaves the cause alone
    wr(RCR_OFS_COMMAND, 32'hA500_0004);
    repeat (2) @(posedge clk_i);
    check({cpu_reset_o, periph_reset_o}, 2'b01);
    wait_quiet(n);
    rd_chk(RCR_OFS_STATUS, 32'h0000_0700, cause_w(RCR_CAUSE_SOFT));
    // pin pulse of 2^(2+1) slow cycles
    wr(RCR_OFS_CONFIG, 32'hA500_0200);
    wr(RCR_OFS_COMMAND, 32'hA500_0008);
    n = 0;
    while (pin_oe_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    check({pin_oe_o, pin_o}, 2'b10);
    n = 0;
    while (pin_oe_o === 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    check(n >= 112 && n <= 144, 1'b1);
    wait_quiet(n);
    rd_chk(RCR_OFS_STATUS, 32'h0000_0000, 32'h0000_0000);
    // pin falling edge with pin reset off
    wr(RCR_OFS_CONFIG, 32'hA500_0010);
    ext_pin <= 1'b0;
    repeat (60) @(posedge clk_i);
    check({irq_o, cpu_reset_o}, 2'b10);
    rd_chk(RCR_OFS_STATUS, 32'h0001_0001, 32'h0000_0001);
    ext_pin <= 1'b1;
    repeat (60) @(posedge clk_i);
    rd_chk(RCR_OFS_STATUS, 32'h0001_0001, 32'h0001_0000);
    check(irq_o, 1'b0);
    wr(RCR_OFS_CONFIG, 32'hA500_0000);
    pin_blip();
    check(irq_o, 1'b0);
    rd_chk(RCR_OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
    // pin reset enabled
    wr(RCR_OFS_CONFIG, 32'hA500_0011);
    ext_pin <= 1'b0;
    repeat (60) @(posedge clk_i);
    check({cpu_reset_o, periph_reset_o, irq_o}, 3'b110);
    ext_pin <= 1'b1;
    wait_quiet(n);
    check(n >= 60 && n <= 100, 1'b1);
    rd_chk(RCR_OFS_STATUS, 32'h0000_0700, cause_w(RCR_CAUSE_PIN));
    // brownout flag and its interrupt
    wr(RCR_OFS_CONFIG, 32'hA501_0000);
    rd_chk(RCR_OFS_STATUS, 32'h0000_0000, 32'h0000_0000);
    brownout_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    brownout_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    check(irq_o, 1'b1);
    rd_chk(RCR_OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
    rd_chk(RCR_OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
    check(irq_o, 1'b0);
    wr(RCR_OFS_CONFIG, 32'hA500_0000);
    brownout_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    brownout_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    check(irq_o, 1'b0);
    rd_chk(RCR_OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
    // watchdog, then sources racing for priority
    watchdog_fault_i <= 1'b1;
    @(posedge clk_i);
    watchdog_fault_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({cpu_reset_o, periph_reset_o}, 2'b11);
    wait_quiet(n);
    rd_chk(RCR_OFS_STATUS, 32'h0000_0700, cause_w(RCR_CAUSE_WDOG));
    brownout_reset_en_i <= 1'b1;
    brownout_i <= 1'b1;
    watchdog_fault_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    brownout_i <= 1'b0;
    watchdog_fault_i <= 1'b0;
    wait_quiet(n);
    rd_chk(RCR_OFS_STATUS, 32'h0000_0700, cause_w(RCR_CAUSE_BROWN));
    power_up_i <= 1'b1;
    watchdog_fault_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    power_up_i <= 1'b0;
    watchdog_fault_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wait_quiet(n);
    rd_chk(RCR_OFS_STATUS, 32'h0000_0700, cause_w(RCR_CAUSE_POWER));
    stop_test();
  end
endmodule
